// ### rtl/slc_pkg.sv
// Constants, field layouts and types shared by the serial line control block
package slc_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] SLC_ADR_CTRL = 8'h00;
  localparam logic [7:0] SLC_ADR_TMO  = 8'h04;
  localparam logic [7:0] SLC_ADR_NTFY = 8'h08;
  localparam logic [7:0] SLC_ADR_STAT = 8'h0C;
  localparam logic [7:0] SLC_ADR_LOGC = 8'h10;
  // In-band flow control characters
  localparam logic [7:0] SLC_XON  = 8'h11;
  localparam logic [7:0] SLC_XOFF = 8'h13;
  // Flow control, electrical mode and DTR mode encodings
  localparam logic [1:0] SLC_FC_NONE = 2'h0;
  localparam logic [1:0] SLC_FC_SW   = 2'h1;
  localparam logic [1:0] SLC_FC_HW   = 2'h2;
  localparam logic [1:0] SLC_EL_232  = 2'h0;
  localparam logic [1:0] SLC_EL_422  = 2'h1;
  localparam logic [1:0] SLC_EL_485  = 2'h2;
  localparam logic [1:0] SLC_DTR_HI  = 2'h0;
  localparam logic [1:0] SLC_DTR_LO  = 2'h1;
  localparam logic [1:0] SLC_DTR_SES = 2'h2;
  localparam logic [1:0] SLC_PAR_NONE = 2'h0;
  // Reset values: no flow control, no parity, one stop bit, logging off
  localparam logic [17:0] SLC_CTRL_RST = 18'h0_0000;
  localparam logic [15:0] SLC_TMO_RST  = 16'h0000;
  localparam logic [15:0] SLC_NTFY_RST = 16'h0000;
  // Log cap in internal memory
  localparam int unsigned SLC_LOG_KBYTES = 10;
  localparam logic [13:0] SLC_LOG_MAX    = 14'(SLC_LOG_KBYTES * 1024);
  // Millisecond tick
  localparam int unsigned SLC_CLK_HZ   = 100_000_000;
  localparam int unsigned SLC_TICK_US  = 1000;
  localparam int unsigned SLC_TICK_CYC = SLC_TICK_US * (SLC_CLK_HZ / 1_000_000);
  localparam int unsigned SLC_BUF_DEPTH = 16;

  typedef struct packed {
    logic       stop2;
    logic [1:0] parity;
    logic       ev_en;
    logic       log_mem;
    logic       log_en;
    logic       host_tcp;
    logic       auto_rel;
    logic       dcd_gate;
    logic       emul;
    logic       modem_en;
    logic       dsr_gate;
    logic [1:0] dtr_mode;
    logic [1:0] elec;
    logic [1:0] flow;
  } slc_ctrl_t;

  typedef enum logic [1:0] {
    SLC_ACC   = 2'b01,
    SLC_DRAIN = 2'b10
  } slc_state_t;
endpackage

// ### rtl/slc_line_ctrl.sv
// Serial port line control, packetizing buffer and event gating
`timescale 1ns/1ps
module slc_line_ctrl
  import slc_pkg::*;
#(
  parameter int unsigned DEPTH    = SLC_BUF_DEPTH,
  parameter int unsigned TICK_CYC = SLC_TICK_CYC
) (
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Sync reset, high
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Write enable
  input  wire logic [7:0]  wb_adr_i,    // Byte address
  input  wire logic [3:0]  wb_sel_i,    // Byte selects
  input  wire logic [31:0] wb_dat_i,    // Write data
  output logic      [31:0] wb_dat_o,    // Read data
  output logic             wb_ack_o,    // Acknowledge
  input  wire logic        rx_valid_i,  // Received byte valid
  input  wire logic [7:0]  rx_data_i,   // Received byte
  output logic             rx_ready_o,  // Byte taken
  output logic             tx_valid_o,  // Flow char to send
  output logic      [7:0]  tx_data_o,   // Flow char
  input  wire logic        tx_ready_i,  // Transmitter took char
  output logic             tx_hold_o,   // Pause serial transmit
  output logic             net_valid_o, // Byte to network
  output logic      [7:0]  net_data_o,  // Network byte
  input  wire logic        net_ready_i, // Network took byte
  input  wire logic        cts_i,       // CTS level
  output logic             rts_o,       // RTS level
  output logic             dtr_o,       // DTR level
  input  wire logic        dsr_i,       // DSR level
  input  wire logic        dcd_i,       // DCD level
  input  wire logic        session_i,   // A session is open
  output logic             conn_req_o,  // Open outgoing, pulse
  output logic             conn_drop_o, // Drop connection, pulse
  output logic             accept_o,    // Remote connect allowed
  output logic             init_req_o,  // Send init string, pulse
  output logic             modem_rel_o, // Release modem, pulse
  output logic             log_wr_o,    // Log this byte, pulse
  input  wire logic        kw_hit_i,    // Keyword detected, pulse
  output logic             notify_o,    // Send notification, pulse
  output logic             cmd_o        // Send port command, pulse
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] HIGH_CNT = CW'(DEPTH - 2);

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  slc_ctrl_t       ctrl_q;
  logic [15:0]     tmo_q;
  logic [15:0]     ntfy_q;
  logic            ack_q;
  logic [31:0]     rdat_q;
  logic [7:0]      mem [DEPTH];
  slc_state_t      state_q;
  slc_state_t      state_d;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   cnt_d;
  logic [AW-1:0]   rdp_q;
  logic [AW-1:0]   rdp_d;
  logic            rdy_q;
  logic            nval_q;
  logic [7:0]      ndat_q;
  logic            txv_q;
  logic [7:0]      txd_q;
  logic            roff_q;
  logic            pause_q;
  logic            rts_q;
  logic            dtr_q;
  logic            dsr_q;
  logic            sess_q;
  logic            req_q;
  logic            drop_q;
  logic            acc_q;
  logic            init_q;
  logic            rel_q;
  logic            logw_q;
  logic [13:0]     logc_q;
  logic            ntf_q;
  logic            cmd_q;
  logic [15:0]     gap_q;
  logic [15:0]     nms_q;
  logic [31:0]     tick_q;

  // Bus decode
  wire         req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire         wr      = wb_cyc_i & wb_stb_i & ack_q & wb_we_i; // Lands on the edge that sees ack
  wire         wr_ctrl = wr & (wb_adr_i == SLC_ADR_CTRL);
  wire [31:0]  ctrl_m  = wmerge({14'h0000, ctrl_q}, wb_dat_i, wb_sel_i);
  wire [31:0]  tmo_m   = wmerge({16'h0000, tmo_q}, wb_dat_i, wb_sel_i);
  wire [31:0]  ntfy_m  = wmerge({16'h0000, ntfy_q}, wb_dat_i, wb_sel_i);
  wire         cfg_chg = wr_ctrl & (ctrl_m[17:0] != ctrl_q);
  wire [31:0]  stat_w  = {10'h000, state_q, logc_q >= SLC_LOG_MAX, acc_q, roff_q, pause_q,
                          cts_i, dcd_i, dsr_i, dtr_q, rts_q, 3'h0, 8'(cnt_q)};
  wire [31:0]  rd_d    = (wb_adr_i == SLC_ADR_CTRL) ? {14'h0000, ctrl_q} :
                         (wb_adr_i == SLC_ADR_TMO)  ? {16'h0000, tmo_q} :
                         (wb_adr_i == SLC_ADR_NTFY) ? {16'h0000, ntfy_q} :
                         (wb_adr_i == SLC_ADR_STAT) ? stat_w :
                         (wb_adr_i == SLC_ADR_LOGC) ? {18'h0_0000, logc_q} : 32'h0000_0000;

  // Mode qualifiers
  wire fc_on     = ctrl_q.elec != SLC_EL_485;
  wire sw_fc     = fc_on & (ctrl_q.flow == SLC_FC_SW);
  wire hw_fc     = fc_on & (ctrl_q.flow == SLC_FC_HW);
  wire modem_act = ctrl_q.modem_en & ctrl_q.host_tcp;
  wire dd_eff    = ~ctrl_q.modem_en & (ctrl_q.elec == SLC_EL_232);
  wire dsr_eff   = dd_eff & ctrl_q.dsr_gate;
  wire tick      = tick_q == 32'(TICK_CYC - 1);

  // Receive path
  wire rx_fire   = rx_valid_i & rdy_q;
  wire is_xon    = sw_fc & (rx_data_i == SLC_XON);
  wire is_xoff   = sw_fc & (rx_data_i == SLC_XOFF);
  wire data_byte = rx_fire & ~is_xon & ~is_xoff;
  wire near_full = cnt_q >= HIGH_CNT;
  wire gap_hit   = (tmo_q == 16'h0000) | (gap_q >= tmo_q);
  wire flush     = (cnt_q == FULL_CNT) | ((cnt_q != '0) & gap_hit);
  wire last_out  = CW'(rdp_q) == cnt_q - CW'(1);
  wire log_full  = ctrl_q.log_mem & (logc_q >= SLC_LOG_MAX);

  // Outputs and helpers
  wire dtr_d = ~dd_eff ? (modem_act ? session_i : 1'b1) :
               (ctrl_q.dtr_mode == SLC_DTR_HI) ? 1'b1 :
               (ctrl_q.dtr_mode == SLC_DTR_LO) ? 1'b0 : session_i;
  wire dsr_rise = dsr_i & ~dsr_q;
  wire dsr_fall = ~dsr_i & dsr_q;
  wire ntf_ok   = nms_q >= ntfy_q;
  wire pause_d  = hw_fc ? ~cts_i :
                  sw_fc ? ((rx_fire & is_xoff) | (pause_q & ~(rx_fire & is_xon))) : 1'b0;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rdp_d   = rdp_q;
    case (state_q)
      SLC_ACC:
      begin
        if (data_byte)
          cnt_d = cnt_q + CW'(1);
        else if (flush)
        begin
          state_d = SLC_DRAIN;
          rdp_d   = '0;
        end
      end
      SLC_DRAIN:
      begin
        if (net_ready_i & nval_q)
        begin
          if (last_out)
          begin
            state_d = SLC_ACC;
            cnt_d   = '0;
          end
          else
            rdp_d = rdp_q + AW'(1);
        end
      end
      default:
      begin
        state_d = SLC_ACC;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (data_byte & (state_q == SLC_ACC))
      mem[AW'(cnt_q)] <= rx_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= SLC_CTRL_RST;
      tmo_q  <= SLC_TMO_RST;
      ntfy_q <= SLC_NTFY_RST;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= rd_d;
      if (wr_ctrl)
        ctrl_q <= slc_ctrl_t'(ctrl_m[17:0]);
      if (wr & (wb_adr_i == SLC_ADR_TMO))
        tmo_q <= tmo_m[15:0];
      if (wr & (wb_adr_i == SLC_ADR_NTFY))
        ntfy_q <= ntfy_m[15:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= SLC_ACC;
      cnt_q   <= '0;
      rdp_q   <= '0;
      rdy_q   <= 1'b0;
      nval_q  <= 1'b0;
      ndat_q  <= 8'h00;
      tick_q  <= 32'h0000_0000;
      gap_q   <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rdp_q   <= rdp_d;
      rdy_q   <= (state_d == SLC_ACC) & (cnt_d < FULL_CNT) & ~rx_fire;
      nval_q  <= state_d == SLC_DRAIN;
      ndat_q  <= mem[rdp_d];
      tick_q  <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
      if (data_byte)
        gap_q <= 16'h0000;
      else if (tick & (gap_q != 16'hFFFF))
        gap_q <= gap_q + 16'h0001;
    end
  end

  // Flow control: XOFF near full, XON once drained
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txv_q   <= 1'b0;
      txd_q   <= 8'h00;
      roff_q  <= 1'b0;
      pause_q <= 1'b0;
      rts_q   <= 1'b1;
    end
    else
    begin
      pause_q <= pause_d;
      rts_q   <= ~hw_fc | ~near_full;
      if (txv_q)
      begin
        if (tx_ready_i)
          txv_q <= 1'b0;
      end
      else if (sw_fc & near_full & ~roff_q)
      begin
        txv_q  <= 1'b1;
        txd_q  <= SLC_XOFF;
        roff_q <= 1'b1;
      end
      else if (roff_q & (~sw_fc | (cnt_q == '0)))
      begin
        txv_q  <= sw_fc;
        txd_q  <= SLC_XON;
        roff_q <= 1'b0;
      end
    end
  end

  // Modem and connection signals
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dtr_q  <= 1'b1;
      dsr_q  <= 1'b0;
      sess_q <= 1'b0;
      req_q  <= 1'b0;
      drop_q <= 1'b0;
      acc_q  <= 1'b0;
      init_q <= 1'b0;
      rel_q  <= 1'b0;
    end
    else
    begin
      dtr_q  <= dtr_d;
      dsr_q  <= dsr_i;
      sess_q <= session_i;
      req_q  <= dsr_eff & dsr_rise;
      drop_q <= dsr_fall & (dsr_eff | ctrl_q.emul);
      acc_q  <= (~dsr_eff | dsr_i) & (~(modem_act & ctrl_q.dcd_gate) | dcd_i);
      init_q <= modem_act & ((dtr_d & ~dtr_q) | cfg_chg);
      rel_q  <= modem_act & ctrl_q.auto_rel & sess_q & ~session_i;
    end
  end

  // Logging and keyword events
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      logw_q <= 1'b0;
      logc_q <= 14'h0000;
      ntf_q  <= 1'b0;
      cmd_q  <= 1'b0;
      nms_q  <= 16'hFFFF;
    end
    else
    begin
      logw_q <= ctrl_q.log_en & data_byte & ~log_full;
      if (~ctrl_q.log_en)
        logc_q <= 14'h0000;
      else if (data_byte & ~log_full & (logc_q != 14'h3FFF))
        logc_q <= logc_q + 14'h0001;
      ntf_q <= ctrl_q.ev_en & kw_hit_i & ntf_ok;
      cmd_q <= ctrl_q.ev_en & kw_hit_i;
      if (ctrl_q.ev_en & kw_hit_i & ntf_ok)
        nms_q <= 16'h0000;
      else if (tick & (nms_q != 16'hFFFF))
        nms_q <= nms_q + 16'h0001;
    end
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdat_q;
  assign rx_ready_o  = rdy_q;
  assign tx_valid_o  = txv_q;
  assign tx_data_o   = txd_q;
  assign tx_hold_o   = pause_q;
  assign net_valid_o = nval_q;
  assign net_data_o  = ndat_q;
  assign rts_o       = rts_q;
  assign dtr_o       = dtr_q;
  assign conn_req_o  = req_q;
  assign conn_drop_o = drop_q;
  assign accept_o    = acc_q;
  assign init_req_o  = init_q;
  assign modem_rel_o = rel_q;
  assign log_wr_o    = logw_q;
  assign notify_o    = ntf_q;
  assign cmd_o       = cmd_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  xoff_pause_a: assert property (sw_fc && rx_fire && rx_data_i == SLC_XOFF && !hw_fc |=> tx_hold_o)
    else $error("XOFF did not pause transmit");
  rs485_nofc_a: assert property ($past(ctrl_q.elec == SLC_EL_485) |-> !tx_hold_o && rts_o)
    else $error("Flow control active in RS485");
  dtr_low_a: assert property ($past(dd_eff && ctrl_q.dtr_mode == SLC_DTR_LO) |-> !dtr_o)
    else $error("DTR not low in low mode");
  dsr_req_a: assert property (dsr_eff && dsr_i && !dsr_q |=> conn_req_o ##1 !conn_req_o)
    else $error("DSR rise gave no single request");
  emul_drop_a: assert property (ctrl_q.emul && !dsr_i && dsr_q |=> conn_drop_o)
    else $error("DSR fall did not drop in emulation");
  zero_tmo_a: assert property (state_q == SLC_ACC && cnt_q != '0 && tmo_q == 16'h0000 && !data_byte
                               |=> state_q == SLC_DRAIN && net_valid_o)
    else $error("Zero timeout did not flush");
  gap_clear_a: assert property (data_byte |=> gap_q == 16'h0000)
    else $error("Gap timer not restarted");
  log_cap_a: assert property (log_full |=> !log_wr_o)
    else $error("Log written past cap");
  ev_gate_a: assert property (!ctrl_q.ev_en |=> !notify_o && !cmd_o)
    else $error("Event reaction while disabled");
  cmd_now_a: assert property (ctrl_q.ev_en && kw_hit_i |=> cmd_o)
    else $error("Port command delayed");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles");
endmodule

// ### tb/slc_serial_dev.sv
// Model of the attached serial device: offers bytes and obeys XON/XOFF
`timescale 1ns/1ps
module slc_serial_dev
  import slc_pkg::*;
(
  input  wire logic       clk_i,  // Clock
  input  wire logic       rst_i,  // Reset
  output logic            rxv_o,  // Byte offered
  output logic      [7:0] rxd_o,  // Byte
  input  wire logic       rxr_i,  // Byte taken
  input  wire logic       txv_i,  // Flow char offered
  input  wire logic [7:0] txd_i,  // Flow char
  output logic            txr_o   // Flow char taken
);
  logic [7:0] q[$];
  int         n_xoff = 0;
  int         n_xon  = 0;
  logic       paused;

  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask

  always @(posedge clk_i)
  begin
    txr_o <= ($urandom_range(0, 3) != 0);
    if (rst_i)
    begin
      rxv_o  <= 1'b0;
      rxd_o  <= 8'h00;
      paused <= 1'b0;
    end
    else
    begin
      if (txv_i && txr_o && txd_i == SLC_XOFF)
      begin
        paused <= 1'b1;
        n_xoff++;
      end
      if (txv_i && txr_o && txd_i == SLC_XON)
      begin
        paused <= 1'b0;
        n_xon++;
      end
      // Released data line must not look like a held byte
      if (rxv_o && rxr_i)
      begin
        rxv_o <= 1'b0;
        rxd_o <= ~rxd_o;
      end
      else if (!rxv_o && q.size() > 0 && !paused)
      begin
        rxv_o <= 1'b1;
        rxd_o <= q.pop_front();
      end
    end
  end
endmodule

// ### tb/slc_line_ctrl_tb.sv
// Self-checking bench for the serial line control block
`timescale 1ns/1ps
module slc_line_ctrl_tb;
  import slc_pkg::*;
  localparam int unsigned DEP = 8;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, we, cts, dsr, dcd, ses, kw;
  logic        nrdy = 1'b0;
  logic [7:0]  adr;
  logic [31:0] wdat, rd, rdat;
  logic        ack, rxv, rxr, txv, txr, hold, nv, rts, dtr, acc;
  logic [7:0]  rxd, txd, nd;
  logic [6:0]  pulse;
  int          pc[7];
  logic [7:0]  exp_q[$];
  logic [7:0]  got_q[$];
  int          fails = 0;
  int          samples_checked = 0;
  slc_ctrl_t   c;

  slc_line_ctrl #(.DEPTH(DEP), .TICK_CYC(10)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .rx_valid_i(rxv), .rx_data_i(rxd),
    .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .tx_hold_o(hold),
    .net_valid_o(nv), .net_data_o(nd), .net_ready_i(nrdy), .cts_i(cts), .rts_o(rts), .dtr_o(dtr),
    .dsr_i(dsr), .dcd_i(dcd), .session_i(ses), .conn_req_o(pulse[0]), .conn_drop_o(pulse[1]),
    .accept_o(acc), .init_req_o(pulse[2]), .modem_rel_o(pulse[3]), .log_wr_o(pulse[6]),
    .kw_hit_i(kw), .notify_o(pulse[4]), .cmd_o(pulse[5]));

  slc_serial_dev dev (
    .clk_i(clk_i), .rst_i(rst_i), .rxv_o(rxv), .rxd_o(rxd), .rxr_i(rxr),
    .txv_i(txv), .txd_i(txd), .txr_o(txr));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Network side stalls at random; pulses are counted per window
  always @(posedge clk_i)
  begin
    nrdy <= ($urandom_range(0, 3) != 0);
    if (nv && nrdy)
      got_q.push_back(nd);
    foreach (pc[i])
      pc[i] += pulse[i];
  end

  function automatic logic exp_dtr(input logic [1:0] m, input logic s);
    return (m == SLC_DTR_HI) ? 1'b1 : (m == SLC_DTR_LO) ? 1'b0 : s;
  endfunction

  function automatic logic [7:0] rbyte();
    logic [7:0] b = 8'($urandom);
    return (b == SLC_XON || b == SLC_XOFF) ? 8'h55 : b;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bail(input string nm);
    fails++;
    $display("FAIL %s expected done seen timeout", nm);
    close_out();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic clr();
    tick(3);
    foreach (pc[i])
      pc[i] = 0;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rdat = rd;
    cyc <= 1'b0;
    if (k >= 50)
      bail("wb_ack");
    @(posedge clk_i);
  endtask

  task automatic wctl();
    wb(1'b1, SLC_ADR_CTRL, {14'h0000, c});
  endtask

  task automatic send(input int n);
    logic [7:0] b;
    repeat (n)
    begin
      b = rbyte();
      dev.put(b);
      exp_q.push_back(b);
    end
  endtask

  task automatic drain(input string nm, input int lim);
    int k = 0;
    while (got_q.size() < exp_q.size() && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= lim)
      bail(nm);
    while (exp_q.size() > 0)
      chk(nm, {24'h00_0000, exp_q.pop_front()}, {24'h00_0000, got_q.pop_front()});
  endtask

  task automatic dsr_cycle(input int er, input int ed, input int ah, input int al);
    clr();
    dsr <= 1'b1;
    tick(4);
    chk("conn_req", er, pc[0]);
    if (ah >= 0)
      chk("accept_hi", ah, {31'h0, acc});
    dsr <= 1'b0;
    tick(4);
    chk("conn_drop", ed, pc[1]);
    if (al >= 0)
      chk("accept_lo", al, {31'h0, acc});
  endtask

  task automatic kw_pulse();
    kw <= 1'b1;
    @(posedge clk_i);
    kw <= 1'b0;
    @(posedge clk_i);
  endtask

  initial
  begin
    int x0;
    int y0;
    rst_i = 1'b1;
    {cyc, we, dsr, dcd, ses, kw} = '0;
    cts  = 1'b1;
    adr  = 8'h00;
    wdat = 32'h0000_0000;
    c    = '0;
    void'($urandom(31));
    tick(4);
    rst_i <= 1'b0;
    tick(2);
    chk("dtr_rst", 1, {31'h0, dtr});
    chk("rts_rst", 1, {31'h0, rts});
    wb(1'b0, SLC_ADR_CTRL, 32'h0000_0000);
    chk("ctrl_rst", 32'h0000_0000, rdat);
    wb(1'b0, SLC_ADR_STAT, 32'h0000_0000);
    chk("stat_rst", 32'h0014_9800, rdat);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdat);
    wb(1'b1, SLC_ADR_TMO, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      send(1);
      drain("flush_tmo0", 20);
    end
    $display("test registers_and_zero_timeout finished");
    c.log_en = 1'b1;
    wctl();
    wb(1'b1, SLC_ADR_TMO, 32'h0000_03E8);
    clr();
    send(DEP);
    drain("flush_full", 300);
    chk("log_wr", DEP, pc[6]);
    wb(1'b0, SLC_ADR_LOGC, 32'h0000_0000);
    chk("log_cnt", DEP, rdat);
    c.log_en = 1'b0;
    wctl();
    wb(1'b1, SLC_ADR_TMO, 32'h0000_0004);
    for (int i = 0; i < 3; i++)
    begin
      send(1);
      tick(25);
    end
    chk("early_flush", 0, got_q.size());
    drain("flush_gap", 100);
    $display("test buffer_flush finished");
    c.flow = SLC_FC_SW;
    wctl();
    wb(1'b1, SLC_ADR_TMO, 32'h0000_0005);
    x0 = dev.n_xoff;
    y0 = dev.n_xon;
    send(DEP - 1);
    drain("flow_sw", 2000);
    tick(20);
    chk("xoff_sent", 1, dev.n_xoff - x0);
    chk("xon_sent", 1, dev.n_xon - y0);
    dev.put(SLC_XOFF);
    tick(10);
    chk("hold_xoff", 1, {31'h0, hold});
    dev.put(SLC_XON);
    tick(10);
    chk("hold_xon", 0, {31'h0, hold});
    c.flow = SLC_FC_HW;
    wctl();
    cts <= 1'b0;
    tick(3);
    chk("hold_cts", 1, {31'h0, hold});
    c.elec = SLC_EL_485;
    wctl();
    tick(3);
    chk("hold_485", 0, {31'h0, hold});
    cts <= 1'b1;
    c.flow = SLC_FC_SW;
    wctl();
    dev.put(SLC_XOFF);
    exp_q.push_back(SLC_XOFF);
    drain("xoff_485", 300);
    chk("hold_485_sw", 0, {31'h0, hold});
    $display("test flow_control finished");
    c = '0;
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 2; s++)
      begin
        c.dtr_mode = 2'(m);
        wctl();
        ses <= 1'(s);
        tick(3);
        chk("dtr_mode", {31'h0, exp_dtr(2'(m), 1'(s))}, {31'h0, dtr});
      end
    ses <= 1'b0;
    c.dtr_mode = SLC_DTR_LO;
    c.elec = SLC_EL_422;
    wctl();
    tick(3);
    chk("dtr_422", 1, {31'h0, dtr});
    c = '0;
    c.dsr_gate = 1'b1;
    wctl();
    dsr_cycle(1, 1, 1, 0);
    c.modem_en = 1'b1;
    wctl();
    dsr_cycle(0, 0, -1, -1);
    c = '0;
    c.emul = 1'b1;
    wctl();
    dsr_cycle(0, 1, 1, 1);
    $display("test dtr_dsr finished");
    c = '0;
    c.modem_en = 1'b1;
    c.host_tcp = 1'b1;
    c.auto_rel = 1'b1;
    wctl();
    clr();
    ses <= 1'b1;
    tick(4);
    chk("init_dtr", 1, pc[2]);
    ses <= 1'b0;
    tick(4);
    chk("modem_rel", 1, pc[3]);
    clr();
    c.parity = 2'h1;
    wctl();
    tick(4);
    chk("init_cfg", 1, pc[2]);
    c.host_tcp = 1'b0;
    wctl();
    clr();
    ses <= 1'b1;
    tick(4);
    chk("init_udp", 0, pc[2]);
    ses <= 1'b0;
    c = '0;
    c.modem_en = 1'b1;
    c.host_tcp = 1'b1;
    c.dcd_gate = 1'b1;
    wctl();
    tick(3);
    chk("accept_dcd0", 0, {31'h0, acc});
    dcd <= 1'b1;
    tick(3);
    chk("accept_dcd1", 1, {31'h0, acc});
    $display("test modem finished");
    c = '0;
    wctl();
    wb(1'b1, SLC_ADR_NTFY, 32'h0000_0064);
    clr();
    kw_pulse();
    tick(3);
    chk("cmd_off", 0, pc[5]);
    chk("notify_off", 0, pc[4]);
    c.ev_en = 1'b1;
    wctl();
    clr();
    kw_pulse();
    tick(5);
    kw_pulse();
    tick(4);
    chk("cmd_both", 2, pc[5]);
    chk("notify_once", 1, pc[4]);
    tick(1100);
    clr();
    kw_pulse();
    tick(4);
    chk("notify_again", 1, pc[4]);
    $display("test events finished");
    close_out();
  end
endmodule
